// ===== ast_pkg.sv
// constants and types shared by the asynchronous serial transceiver
package ast_pkg;
	// register map of the interrupt block
	localparam logic [3:0] AST_REG_STATUS = 4'h0;
	localparam logic [3:0] AST_REG_ENABLE = 4'h4;
	localparam logic [3:0] AST_REG_CLEAR  = 4'h8;
	// status and enable bit positions
	localparam int AST_EV_RX_READY = 0;
	localparam int AST_EV_TX_EMPTY = 1;
	localparam int AST_EV_PARITY   = 2;
	localparam int AST_EV_FRAMING  = 3;
	localparam int AST_EV_OVERRUN  = 4;
	localparam int AST_EV_COUNT    = 5;
	// timing in sixteen-times ticks, then status and enable reset values
	localparam logic [4:0] AST_TICKS_HALF = 5'h07;
	localparam logic [4:0] AST_TICKS_BIT  = 5'h0f;
	localparam logic [4:0] AST_TICKS_1P5  = 5'h17;
	localparam logic [4:0] AST_TICKS_2    = 5'h1f;
	localparam logic [4:0] AST_EV_RESET   = 5'h00;
	localparam logic [4:0] AST_EN_RESET   = 5'h00;
	// synchroniser reset: each pin's idle level, only the serial input rests high
	localparam logic [18:0] AST_SYNC_RESET = 19'h00800;

	// control word captured from the pins
	typedef struct packed {
		logic [1:0] length_sel; // {hi, lo}: 0 = 5 bits .. 3 = 8 bits
		logic       parity_inhibit;
		logic       even_parity_sel;
		logic       stop_bits_sel;
	} ast_ctrl_t;
	localparam ast_ctrl_t AST_CTRL_RESET = '{length_sel: 2'h3, parity_inhibit: 1'b1,
		even_parity_sel: 1'b0, stop_bits_sel: 1'b0};

	// frame states, shared by both directions
	typedef enum logic [2:0] {
		AST_IDLE   = 3'b000,
		AST_START  = 3'b001,
		AST_DATA   = 3'b010,
		AST_PARITY = 3'b011,
		AST_STOP   = 3'b100
	} ast_state_t;
endpackage

// ===== ast_transceiver.sv
// asynchronous serial transceiver: pin-level receiver and transmitter with interrupt registers
`timescale 1ns/1ns
module ast_transceiver (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        resetn,
	// control word pins
	input  wire logic        length_sel_lo,
	input  wire logic        length_sel_hi,
	input  wire logic        parity_inhibit,
	input  wire logic        even_parity_sel,
	input  wire logic        stop_bits_sel,
	input  wire logic        control_word_load,
	// serial side
	input  wire logic        tx_bit_clock_16x,
	input  wire logic        rx_serial_in,
	output logic             tx_serial_out,
	// parallel transmit side
	input  wire logic [7:0]  tx_char_in,
	input  wire logic        tx_buffer_load,
	// parallel receive side
	input  wire logic        rx_outputs_disable,
	input  wire logic        rx_ready_clear,
	output logic [7:0]       rx_char_out,
	output logic             rx_char_oe_n,
	// status pins
	input  wire logic        status_outputs_disable,
	output logic             parity_err_flag,
	output logic             framing_err_flag,
	output logic             overrun_err_flag,
	output logic             rx_char_ready,
	output logic             tx_buffer_empty,
	output logic             status_oe_n,
	// register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic [7:0]       reg_rdata,
	output logic             irq
);
	localparam int NSYNC = 19;

	// pin synchronisers: every pin outside the register port passes two flops before use
	// reset to the pins' idle levels, else the edge detectors see a false load or tick after reset
	logic [NSYNC-1:0] sync1_q;
	logic [NSYNC-1:0] sync2_q;
	logic [NSYNC-1:0] pins;
	assign pins = {length_sel_hi, length_sel_lo, parity_inhibit, even_parity_sel, stop_bits_sel,
		control_word_load, tx_bit_clock_16x, rx_serial_in, tx_buffer_load, rx_outputs_disable,
		rx_ready_clear, status_outputs_disable, tx_char_in[6:0]};
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge mclk or negedge resetn) begin
				if (!resetn) begin
					sync1_q[gi] <= ast_pkg::AST_SYNC_RESET[gi];
					sync2_q[gi] <= ast_pkg::AST_SYNC_RESET[gi];
				end else begin
					sync1_q[gi] <= pins[gi];
					sync2_q[gi] <= sync1_q[gi];
				end
			end
		end
	endgenerate

	// top transmit bit synchronised apart, kept out of the vector for readability
	logic tx8_s1_q;
	logic tx8_s2_q;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			tx8_s1_q <= 1'b0;
			tx8_s2_q <= 1'b0;
		end else begin
			tx8_s1_q <= tx_char_in[7];
			tx8_s2_q <= tx8_s1_q;
		end
	end

	ast_pkg::ast_ctrl_t ctrl_pins;
	logic       ld_ctrl_s, clk16_s, rx_s, tx_load_s, rx_dis_s, rdy_clr_s, st_dis_s;
	logic [7:0] tx_char_s;
	assign ctrl_pins = ast_pkg::ast_ctrl_t'(sync2_q[18:14]);
	assign ld_ctrl_s = sync2_q[13];
	assign clk16_s   = sync2_q[12];
	assign rx_s      = sync2_q[11];
	assign tx_load_s = sync2_q[10];
	assign rx_dis_s  = sync2_q[9];
	assign rdy_clr_s = sync2_q[8];
	assign st_dis_s  = sync2_q[7];
	assign tx_char_s = {tx8_s2_q, sync2_q[6:0]};

	// edge detectors on the synchronised clock and load strobe
	logic clk16_last_q, load_last_q;
	logic tick, load_rise;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			clk16_last_q <= 1'b0;
			load_last_q  <= 1'b0;
		end else begin
			clk16_last_q <= clk16_s;
			load_last_q  <= tx_load_s;
		end
	end
	assign tick      = clk16_s & ~clk16_last_q;     // one pulse per external 16x period
	assign load_rise = tx_load_s & ~load_last_q;

	// control register: transparent while load is high
	ast_pkg::ast_ctrl_t ctrl_q;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			ctrl_q <= ast_pkg::AST_CTRL_RESET;
		else if (ld_ctrl_s)
			ctrl_q <= ctrl_pins;
	end

	// derived frame format
	logic [2:0] last_bit;
	logic [7:0] len_mask;
	logic [4:0] stop_ticks;
	assign last_bit   = {1'b1, ctrl_q.length_sel} + 3'h1 - 3'h1 - 3'h4 + 3'h4; // 5..8 bits -> index 4..7
	assign len_mask   = 8'hff >> (2'h3 - ctrl_q.length_sel);
	assign stop_ticks = !ctrl_q.stop_bits_sel ? ast_pkg::AST_TICKS_BIT :
		(ctrl_q.length_sel == 2'h0) ? ast_pkg::AST_TICKS_1P5 : ast_pkg::AST_TICKS_2;

	// transmit holding buffer; a load while full overwrites the waiting character
	logic [7:0] tx_buf_q;
	logic       tx_empty_q;
	logic       tx_take;
	ast_pkg::ast_state_t tx_state_q;
	assign tx_take = (tx_state_q == ast_pkg::AST_IDLE) && !tx_empty_q;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			tx_buf_q   <= 8'h00;
			tx_empty_q <= 1'b1;
		end else if (load_rise) begin
			tx_buf_q   <= tx_char_s & len_mask; // high inputs beyond length ignored
			tx_empty_q <= 1'b0;
		end else if (tx_take)
			tx_empty_q <= 1'b1;
	end

	// transmit shifter: start, data lsb first, parity, stops
	logic [7:0] tx_shift_q;
	logic [2:0] tx_bit_q;
	logic [4:0] tx_cnt_q;
	logic       tx_par_q;
	logic       tx_out_q;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			tx_state_q <= ast_pkg::AST_IDLE;
			tx_shift_q <= 8'h00;
			tx_bit_q   <= 3'h0;
			tx_cnt_q   <= 5'h00;
			tx_par_q   <= 1'b0;
			tx_out_q   <= 1'b1; // line idles high
		end else begin
			if (tick && tx_state_q != ast_pkg::AST_IDLE)
				tx_cnt_q <= tx_cnt_q + 5'h01;
			case (tx_state_q)
				ast_pkg::AST_IDLE: begin
					if (tx_take) begin
						tx_shift_q <= tx_buf_q;
						tx_par_q   <= (^tx_buf_q) ^ ~ctrl_q.even_parity_sel;
						tx_out_q   <= 1'b0; // start bit
						tx_cnt_q   <= 5'h00;
						tx_state_q <= ast_pkg::AST_START;
					end
				end
				ast_pkg::AST_START: begin
					if (tick && tx_cnt_q == ast_pkg::AST_TICKS_BIT) begin
						tx_out_q   <= tx_shift_q[0];
						tx_bit_q   <= 3'h0;
						tx_cnt_q   <= 5'h00;
						tx_state_q <= ast_pkg::AST_DATA;
					end
				end
				ast_pkg::AST_DATA: begin
					if (tick && tx_cnt_q == ast_pkg::AST_TICKS_BIT) begin
						tx_cnt_q <= 5'h00;
						if (tx_bit_q == last_bit) begin
							// inhibited parity skips the parity slot
							tx_out_q   <= ctrl_q.parity_inhibit ? 1'b1 : tx_par_q;
							tx_state_q <= ctrl_q.parity_inhibit ? ast_pkg::AST_STOP : ast_pkg::AST_PARITY;
						end else begin
							tx_out_q   <= tx_shift_q[1];
							tx_shift_q <= tx_shift_q >> 1;
							tx_bit_q   <= tx_bit_q + 3'h1;
						end
					end
				end
				ast_pkg::AST_PARITY: begin
					if (tick && tx_cnt_q == ast_pkg::AST_TICKS_BIT) begin
						tx_out_q   <= 1'b1;
						tx_cnt_q   <= 5'h00;
						tx_state_q <= ast_pkg::AST_STOP;
					end
				end
				ast_pkg::AST_STOP: begin
					if (tick && tx_cnt_q == stop_ticks) begin // 1, 1.5 or 2 stop bits
						tx_cnt_q   <= 5'h00;
						tx_state_q <= ast_pkg::AST_IDLE;
					end
				end
				default: tx_state_q <= ast_pkg::AST_IDLE;
			endcase
		end
	end

	// receiver: edge hunt, mid-bit sampling
	ast_pkg::ast_state_t rx_state_q;
	logic [7:0] rx_shift_q;
	logic [2:0] rx_bit_q;
	logic [4:0] rx_cnt_q;
	logic       rx_last_q;
	logic       rx_par_q;
	logic       rx_done;
	logic [7:0] rx_just;
	assign rx_done = (rx_state_q == ast_pkg::AST_STOP) && tick && rx_cnt_q == ast_pkg::AST_TICKS_BIT;
	assign rx_just = rx_shift_q >> (2'h3 - ctrl_q.length_sel); // first bit lands on bit 0
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rx_state_q <= ast_pkg::AST_IDLE;
			rx_shift_q <= 8'h00;
			rx_bit_q   <= 3'h0;
			rx_cnt_q   <= 5'h00;
			rx_last_q  <= 1'b1;
			rx_par_q   <= 1'b0;
		end else if (tick) begin
			rx_last_q <= rx_s;
			rx_cnt_q  <= rx_cnt_q + 5'h01;
			case (rx_state_q)
				ast_pkg::AST_IDLE: begin
					rx_cnt_q <= 5'h00;
					if (rx_last_q && !rx_s)
						rx_state_q <= ast_pkg::AST_START; // falling edge
				end
				ast_pkg::AST_START: begin
					if (rx_cnt_q == ast_pkg::AST_TICKS_HALF) begin
						// a start bit gone high at its centre was a glitch
						rx_state_q <= rx_s ? ast_pkg::AST_IDLE : ast_pkg::AST_DATA;
						rx_cnt_q   <= 5'h00;
						rx_bit_q   <= 3'h0;
					end
				end
				ast_pkg::AST_DATA: begin
					if (rx_cnt_q == ast_pkg::AST_TICKS_BIT) begin
						rx_cnt_q   <= 5'h00;
						rx_shift_q <= {rx_s, rx_shift_q[7:1]}; // lsb first
						rx_bit_q   <= rx_bit_q + 3'h1;
						if (rx_bit_q == last_bit)
							rx_state_q <= ctrl_q.parity_inhibit ? ast_pkg::AST_STOP : ast_pkg::AST_PARITY;
					end
				end
				ast_pkg::AST_PARITY: begin
					if (rx_cnt_q == ast_pkg::AST_TICKS_BIT) begin
						rx_cnt_q   <= 5'h00;
						rx_par_q   <= rx_s;
						rx_state_q <= ast_pkg::AST_STOP;
					end
				end
				ast_pkg::AST_STOP: begin
					// only the first stop is checked; hunting resumes at its centre
					if (rx_cnt_q == ast_pkg::AST_TICKS_BIT)
						rx_state_q <= ast_pkg::AST_IDLE;
				end
				default: rx_state_q <= ast_pkg::AST_IDLE;
			endcase
		end
	end

	// receive buffer and its flags, all updated at the transfer
	logic [7:0] rx_buf_q;
	logic       rx_ready_q, pe_q, fe_q, oe_q;
	logic       par_bad;
	assign par_bad = ~ctrl_q.parity_inhibit & ((^{rx_just, rx_par_q}) ^ ~ctrl_q.even_parity_sel);
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rx_buf_q   <= 8'h00;
			rx_ready_q <= 1'b0;
			pe_q       <= 1'b0;
			fe_q       <= 1'b0;
			oe_q       <= 1'b0;
		end else if (rx_done) begin
			rx_buf_q   <= rx_just;
			rx_ready_q <= 1'b1;          // a clear in this cycle loses to the new character
			pe_q       <= par_bad;
			fe_q       <= !rx_s;
			oe_q       <= rx_ready_q;
		end else if (rdy_clr_s)
			rx_ready_q <= 1'b0;
	end

	// pin outputs, each from a flop; enables low while driving
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			tx_serial_out    <= 1'b1;
			rx_char_out      <= 8'h00;
			rx_char_oe_n     <= 1'b1;
			parity_err_flag  <= 1'b0;
			framing_err_flag <= 1'b0;
			overrun_err_flag <= 1'b0;
			rx_char_ready    <= 1'b0;
			tx_buffer_empty  <= 1'b1;
			status_oe_n      <= 1'b1;
		end else begin
			tx_serial_out    <= tx_out_q;
			rx_char_out      <= rx_buf_q;
			rx_char_oe_n     <= rx_dis_s;
			parity_err_flag  <= pe_q & ~ctrl_q.parity_inhibit;
			framing_err_flag <= fe_q;
			overrun_err_flag <= oe_q;
			rx_char_ready    <= rx_ready_q;
			tx_buffer_empty  <= tx_empty_q;
			status_oe_n      <= st_dis_s;
		end
	end

	// interrupt block: sticky status, enable and write-one-to-clear
	logic [ast_pkg::AST_EV_COUNT-1:0] ev_set, status_q, enable_q, clr;
	logic                             tx_empty_last_q;
	always_comb begin
		ev_set = '0;
		ev_set[ast_pkg::AST_EV_RX_READY] = rx_done;
		ev_set[ast_pkg::AST_EV_TX_EMPTY] = tx_empty_q & ~tx_empty_last_q;
		ev_set[ast_pkg::AST_EV_PARITY]   = rx_done & par_bad;
		ev_set[ast_pkg::AST_EV_FRAMING]  = rx_done & !rx_s;
		ev_set[ast_pkg::AST_EV_OVERRUN]  = rx_done & rx_ready_q;
	end
	assign clr = (reg_write && reg_addr == ast_pkg::AST_REG_CLEAR) ?
		reg_wdata[ast_pkg::AST_EV_COUNT-1:0] : '0;
	// set wins over a clear in the same cycle so no event is lost
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			status_q        <= ast_pkg::AST_EV_RESET;
			tx_empty_last_q <= 1'b1;
		end else begin
			status_q        <= (status_q & ~clr) | ev_set;
			tx_empty_last_q <= tx_empty_q;
		end
	end
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			enable_q <= ast_pkg::AST_EN_RESET;
		else if (reg_write && reg_addr == ast_pkg::AST_REG_ENABLE)
			enable_q <= reg_wdata[ast_pkg::AST_EV_COUNT-1:0];
	end
	// read data for one cycle after the strobe; unmapped and write-only read zero
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 8'h00;
			irq       <= 1'b0;
		end else begin
			irq <= |(status_q & enable_q);
			if (reg_read && reg_addr == ast_pkg::AST_REG_STATUS)
				reg_rdata <= {3'h0, status_q};
			else if (reg_read && reg_addr == ast_pkg::AST_REG_ENABLE)
				reg_rdata <= {3'h0, enable_q};
			else
				reg_rdata <= 8'h00;
		end
	end
endmodule

// ===== ast_chk.sv
// port-level assertion checker of the serial transceiver
`timescale 1ns/1ns
module ast_chk (
	// clock and reset
	input wire logic       mclk,
	input wire logic       resetn,
	// pins
	input wire logic       parity_inhibit,
	input wire logic       control_word_load,
	input wire logic       rx_outputs_disable,
	input wire logic       status_outputs_disable,
	input wire logic       rx_char_oe_n,
	input wire logic       status_oe_n,
	input wire logic       parity_err_flag,
	input wire logic       framing_err_flag,
	input wire logic       overrun_err_flag,
	input wire logic       rx_char_ready,
	input wire logic       tx_serial_out,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_write,
	input wire logic       reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic       irq
);
	logic [4:0] en_q;

	// shadow of the enable register, so irq and read-back can be judged
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			en_q <= ast_pkg::AST_EN_RESET;
		else if (reg_write && reg_addr == ast_pkg::AST_REG_ENABLE)
			en_q <= reg_wdata[4:0];
	end

	default clocking @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	// eight cycles cover both pin synchronisers and the output register
	sequence s_start_low;
		!tx_serial_out [*8];
	endsequence
	property p_start;
		$fell(tx_serial_out) |-> s_start_low;
	endproperty
	property p_rx_oe;
		rx_outputs_disable [*8] |-> rx_char_oe_n;
	endproperty
	property p_st_oe;
		!status_outputs_disable [*8] |-> !status_oe_n;
	endproperty
	property p_pe_off;
		(parity_inhibit && control_word_load) [*8] |-> !parity_err_flag;
	endproperty
	property p_fe_xfer;
		$changed(framing_err_flag) |-> rx_char_ready;
	endproperty
	property p_overrun;
		$rose(overrun_err_flag) |-> rx_char_ready && $past(rx_char_ready);
	endproperty
	property p_irq_off;
		(en_q == 5'h00) [*2] |-> !irq;
	endproperty
	property p_rd_idle;
		!reg_read |=> reg_rdata == 8'h00;
	endproperty
	property p_rd_en;
		reg_read && reg_addr == ast_pkg::AST_REG_ENABLE |=> reg_rdata == {3'h0, en_q};
	endproperty

	a_start: assert property (p_start) else $error("start bit too short");
	a_rx_oe: assert property (p_rx_oe) else $error("char outputs driven while disabled");
	a_st_oe: assert property (p_st_oe) else $error("status outputs floating while enabled");
	a_pe_off: assert property (p_pe_off) else $error("parity flag high while inhibited");
	a_fe_xfer: assert property (p_fe_xfer) else $error("framing flag moved without transfer");
	a_overrun: assert property (p_overrun) else $error("overrun without pending char");
	a_irq_off: assert property (p_irq_off) else $error("irq with all events masked");
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
	a_rd_en: assert property (p_rd_en) else $error("enable read-back differs");
endmodule

bind ast_transceiver ast_chk u_chk (.mclk, .resetn, .parity_inhibit, .control_word_load, .rx_outputs_disable,
	.status_outputs_disable, .rx_char_oe_n, .status_oe_n, .parity_err_flag, .framing_err_flag, .overrun_err_flag,
	.rx_char_ready, .tx_serial_out, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .irq);

// ===== ast_line_model.sv
// serial line partner: sixteen-times clock, frame sender and frame monitor
`timescale 1ns/1ns
module ast_line_model (
	// line pins
	output logic      clk16,
	output logic      ser_out,
	input wire logic  ser_in
);
	int          ticks = 0;
	int          n_bits = 12;
	logic [11:0] rx_q[$];
	int          t_q[$];

	// free running tick clock, eight mclk per tick keeps it well inside mclk/4
	initial clk16 = 1'b0;
	always #200 clk16 = ~clk16;
	initial ser_out = 1'b1; // line rests high between frames
	always @(posedge clk16) ticks++;

	// send bits lsb first, sixteen ticks each, then one idle bit
	task automatic send(input logic [11:0] b, input int n);
		@(posedge clk16);
		for (int i = 0; i <= n; i++) begin
			ser_out <= (i < n) ? b[i] : 1'b1;
			repeat (16) @(posedge clk16);
		end
	endtask

	// find a start edge, then sample at bit centres; no wait after the last
	initial forever begin
		logic [11:0] b;
		int          t;
		@(negedge ser_in);
		t = ticks;
		b = 12'hfff;
		repeat (8) @(posedge clk16);
		for (int i = 0; i < n_bits; i++) begin
			if (i > 0)
				repeat (16) @(posedge clk16);
			b[i] = ser_in;
		end
		rx_q.push_back(b);
		t_q.push_back(t);
	end
endmodule

// ===== test_async_serial_transceiver.sv
// self-checking bench of the serial transceiver against a line partner
`timescale 1ns/1ns
module test_async_serial_transceiver;
	logic       mclk, resetn, length_sel_lo, length_sel_hi, parity_inhibit, even_parity_sel, stop_bits_sel;
	logic       control_word_load, tx_bit_clock_16x, rx_serial_in, tx_serial_out, tx_buffer_load;
	logic       rx_outputs_disable, rx_ready_clear, rx_char_oe_n, status_outputs_disable, parity_err_flag;
	logic       framing_err_flag, overrun_err_flag, rx_char_ready, tx_buffer_empty, status_oe_n;
	logic       reg_write, reg_read, irq;
	logic [3:0] reg_addr;
	logic [7:0] tx_char_in, rx_char_out, reg_wdata, reg_rdata, v;
	logic [4:0] tc [4] = '{5'h01, 5'h0b, 5'h14, 5'h1a};
	int         n_errors = 0;
	int         checks = 0;

	ast_transceiver dut (.mclk, .resetn, .length_sel_lo, .length_sel_hi, .parity_inhibit, .even_parity_sel,
		.stop_bits_sel, .control_word_load, .tx_bit_clock_16x, .rx_serial_in, .tx_serial_out, .tx_char_in,
		.tx_buffer_load, .rx_outputs_disable, .rx_ready_clear, .rx_char_out, .rx_char_oe_n, .status_outputs_disable,
		.parity_err_flag, .framing_err_flag, .overrun_err_flag, .rx_char_ready, .tx_buffer_empty, .status_oe_n,
		.reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .irq);
	ast_line_model line (.clk16(tx_bit_clock_16x), .ser_out(rx_serial_in), .ser_in(tx_serial_out));

	always #25 mclk = ~mclk;

	task automatic report_and_stop;
		if (n_errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %0h expected %0h", $time, seen, exp);
		end
	endtask

	// sample on the falling edge so registered outputs have settled
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge mclk);
		reg_write <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge mclk);
		reg_read <= 1'b0;
		@(negedge mclk);
		d = reg_rdata;
	endtask

	// c = {length hi, length lo, inhibit, even, stop select}
	task automatic ctrl(input logic [4:0] c);
		@(posedge mclk);
		{length_sel_hi, length_sel_lo, parity_inhibit, even_parity_sel, stop_bits_sel} <= c;
		control_word_load <= 1'b1;
		repeat (8) @(posedge mclk);
		control_word_load <= 1'b0;
	endtask

	function automatic logic [11:0] frame(input logic [7:0] d, input logic [4:0] c);
		int         n;
		logic [7:0] m;
		n = 5 + c[4:3];
		m = d & (8'hff >> (8 - n));
		frame = 12'hfff;
		frame[0] = 1'b0;
		for (int i = 0; i < n; i++)
			frame[i + 1] = m[i];
		if (!c[2])
			frame[n + 1] = c[1] ? ^m : ~^m;
	endfunction

	// a second load waits until the first char has left the buffer
	task automatic load(input logic [7:0] d);
		@(posedge mclk);
		tx_char_in <= d;
		tx_buffer_load <= 1'b1;
		repeat (4) @(posedge mclk);
		tx_buffer_load <= 1'b0;
		repeat (16) @(posedge mclk);
		for (int i = 0; i < 4000 && tx_buffer_empty !== 1'b1; i++)
			@(negedge mclk);
		chk(tx_buffer_empty, 1'b1);
	endtask

	task automatic reg_case;
		chk({tx_serial_out, tx_buffer_empty, rx_char_ready, irq, parity_err_flag, framing_err_flag}, 6'h30);
		rd(ast_pkg::AST_REG_STATUS, v);
		chk(v, 8'h00);
		rd(4'hc, v);
		chk(v, 8'h00);
		wr(ast_pkg::AST_REG_ENABLE, 8'hff);
		rd(ast_pkg::AST_REG_ENABLE, v);
		chk(v, 8'h1f);
		wr(ast_pkg::AST_REG_ENABLE, 8'h00);
		rd(ast_pkg::AST_REG_CLEAR, v);
		chk(v, 8'h00);
	endtask

	task automatic oe_case(input logic e);
		@(posedge mclk);
		rx_outputs_disable <= e;
		status_outputs_disable <= e;
		wait_cyc(8);
		chk({rx_char_oe_n, status_oe_n}, {e, e});
	endtask

	// three chars back to back: bits, and start-to-start spacing in ticks
	// the first start may fall between ticks, so spacing is judged from the second frame on
	task automatic tx_case(input logic [4:0] c, input logic [7:0] d0, input logic [7:0] d1);
		int          nb;
		logic [11:0] m;
		nb = 8 + c[4:3] - c[2];
		m = 12'hfff >> (12 - nb);
		ctrl(c);
		line.n_bits = nb;
		line.rx_q.delete();
		line.t_q.delete();
		load(d0);
		load(d1);
		load(~d0);
		for (int i = 0; i < 4000 && line.t_q.size() < 3; i++)
			@(posedge mclk);
		chk(line.rx_q[0] & m, frame(d0, c) & m);
		chk(line.rx_q[1] & m, frame(d1, c) & m);
		chk(line.rx_q[2] & m, frame(~d0, c) & m);
		chk(line.t_q[2] - line.t_q[1], 16 * (nb - 1) + (!c[0] ? 16 : c[4:3] == 2'h0 ? 24 : 32));
	endtask

	// err = {parity, framing, overrun}
	task automatic rx_case(input logic [4:0] c, input logic [7:0] d, input logic [11:0] flip, input logic [2:0] err);
		ctrl(c);
		line.send(frame(d, c) ^ flip, 8 + c[4:3] - c[2]);
		wait_cyc(8);
		chk(rx_char_out, d & (8'hff >> (3 - c[4:3])));
		chk({parity_err_flag, framing_err_flag, overrun_err_flag, rx_char_ready}, {err, 1'b1});
	endtask

	task automatic clr_case;
		@(posedge mclk);
		rx_ready_clear <= 1'b1;
		repeat (4) @(posedge mclk);
		rx_ready_clear <= 1'b0;
		wait_cyc(2);
		chk(rx_char_ready, 1'b0);
	endtask

	// every event has fired by now; unmask one, then clear it
	task automatic irq_case;
		rd(ast_pkg::AST_REG_STATUS, v);
		chk({v, irq}, {8'h1f, 1'b0});
		wr(ast_pkg::AST_REG_ENABLE, 8'h01 << ast_pkg::AST_EV_FRAMING);
		wait_cyc(2);
		chk(irq, 1'b1);
		wr(ast_pkg::AST_REG_CLEAR, 8'h01 << ast_pkg::AST_EV_FRAMING);
		wait_cyc(2);
		rd(ast_pkg::AST_REG_STATUS, v);
		chk({v, irq}, {8'h17, 1'b0});
	endtask

	initial begin
		mclk = 1'b0;
		resetn = 1'b0;
		{length_sel_lo, length_sel_hi, parity_inhibit, even_parity_sel, stop_bits_sel, control_word_load} = 6'h00;
		{tx_char_in, tx_buffer_load, rx_outputs_disable, rx_ready_clear, status_outputs_disable} = 12'h000;
		{reg_addr, reg_wdata, reg_write, reg_read} = 14'h0000;
		repeat (5) @(posedge mclk);
		resetn <= 1'b1;
		wait_cyc(6);
		reg_case();
		oe_case(1'b1);
		oe_case(1'b0);
		for (int i = 0; i < 4; i++)
			tx_case(tc[i], 8'he5 ^ i[7:0], 8'h3a + i[7:0]);
		rx_case(5'h01, 8'hf3, 12'h000, 3'h0);
		clr_case();
		rx_case(5'h1a, 8'h96, 12'h200, 3'h4);
		rx_case(5'h14, 8'h55, 12'h100, 3'h3);
		clr_case();
		rx_case(5'h0b, 8'h2c, 12'h000, 3'h0);
		irq_case();
		report_and_stop();
	end

	// the planned traffic needs about a quarter of this span
	initial begin
		#4_000_000;
		n_errors++;
		report_and_stop();
	end
endmodule
